// ### shared/gpt_pkg.sv
// constants, offsets and carrier types for the general timer unit
package gpt_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_WIDTH_CFG = 8'h00;
  localparam logic [7:0] OFS_A_MODE = 8'h04;
  localparam logic [7:0] OFS_B_MODE = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_RAW_IRQ = 8'h14;
  localparam logic [7:0] OFS_MASKED_IRQ = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h1c;
  localparam logic [7:0] OFS_A_LOAD = 8'h20;
  localparam logic [7:0] OFS_B_LOAD = 8'h24;
  localparam logic [7:0] OFS_A_MATCH = 8'h28;
  localparam logic [7:0] OFS_B_MATCH = 8'h2c;
  localparam logic [7:0] OFS_A_PRESCALE = 8'h30;
  localparam logic [7:0] OFS_B_PRESCALE = 8'h34;
  localparam logic [7:0] OFS_A_COUNT = 8'h38;
  localparam logic [7:0] OFS_B_COUNT = 8'h3c;

  // ****************************************
  // width configuration codes and mode field
  // ****************************************
  localparam logic [2:0] CFG_OS32 = 3'h0;
  localparam logic [2:0] CFG_RTC32 = 3'h1;
  localparam logic [2:0] CFG_HALF16 = 3'h4;
  localparam int MODE_W = 2;
  localparam logic [1:0] MODE_ONE_SHOT = 2'h1;
  localparam logic [1:0] MODE_PERIODIC = 2'h2;

  // ****************************************
  // control and interrupt bit positions
  // ****************************************
  localparam int CTL_A_RUN = 0;
  localparam int CTL_A_STALL = 1;
  localparam int CTL_RTC_OVR = 4;
  localparam int CTL_A_ADC = 5;
  localparam int CTL_B_RUN = 8;
  localparam int CTL_B_STALL = 9;
  localparam int CTL_W = 16;
  localparam int IRQ_A_TO = 0;
  localparam int IRQ_RTC = 3;
  localparam int IRQ_B_TO = 8;
  localparam int IRQ_W = 16;

  // ****************************************
  // reset values and timing
  // ****************************************
  localparam logic [15:0] RST_COUNT = 16'hffff;
  localparam logic [15:0] RST_LOAD = 16'hffff;
  localparam logic [7:0] RST_PRESCALE = 8'h00;
  localparam logic [31:0] RTC_FIRST_LOAD = 32'h0000_0001;
  localparam int RTC_IN_HZ = 32768;
  localparam int RTC_TICK_HZ = 1;
  localparam int RTC_DIV_EDGES = RTC_IN_HZ / RTC_TICK_HZ;
  localparam int RTC_DIV_W = 16;

  // ****************************************
  // register bus request
  // ****************************************
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } gpt_bus_req_t;

endpackage : gpt_pkg

// ### design/gpt_general_timer_unit.sv
// general timer unit: two 16-bit halves, 32-bit one-shot/periodic and rtc modes
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module gpt_general_timer_unit #(
  parameter int RTC_DIV = gpt_pkg::RTC_DIV_EDGES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire gpt_pkg::gpt_bus_req_t bus_req,
  output logic [31:0] rdata,
  // debug halt from the processor
  input wire logic dbg_halt,
  // capture/compare pin 0
  input wire logic capture_compare_pin_0_in,
  output logic capture_compare_pin_0_out,
  output logic capture_compare_pin_0_oe,
  // events out
  output logic irq,
  output logic adc_trigger
);

  // ****************************************
  // state
  // ****************************************
  logic [2:0] cfg_q, cfg_d;
  logic [gpt_pkg::MODE_W-1:0] a_mode_q, a_mode_d, b_mode_q, b_mode_d;
  logic [gpt_pkg::CTL_W-1:0] ctl_q, ctl_d;
  logic [gpt_pkg::IRQ_W-1:0] mask_q, mask_d, raw_q, raw_d;
  logic [1:0][15:0] cnt_q, cnt_d, load_q, load_d, match_q, match_d;
  logic [1:0][7:0] pre_q, pre_d;
  logic [31:0] rdata_q, rdata_d;
  logic adc_q, adc_d;
  logic pin_q, pin_prev_q;
  logic [gpt_pkg::RTC_DIV_W-1:0] div_q, div_d;
  logic [1:0] timeout_evt;
  logic rtc_evt;

  // ****************************************
  // address decode
  // ****************************************
  wire logic [31:0] wdata = bus_req.wdata;
  wire logic wr_cfg = bus_req.wr && bus_req.addr == gpt_pkg::OFS_WIDTH_CFG;
  wire logic wr_a_mode = bus_req.wr && bus_req.addr == gpt_pkg::OFS_A_MODE;
  wire logic wr_b_mode = bus_req.wr && bus_req.addr == gpt_pkg::OFS_B_MODE;
  wire logic wr_ctl = bus_req.wr && bus_req.addr == gpt_pkg::OFS_CTRL;
  wire logic wr_mask = bus_req.wr && bus_req.addr == gpt_pkg::OFS_IRQ_MASK;
  wire logic wr_clear = bus_req.wr && bus_req.addr == gpt_pkg::OFS_IRQ_CLEAR;
  wire logic wr_a_load = bus_req.wr && bus_req.addr == gpt_pkg::OFS_A_LOAD;
  wire logic wr_b_load = bus_req.wr && bus_req.addr == gpt_pkg::OFS_B_LOAD;
  wire logic wr_a_match = bus_req.wr && bus_req.addr == gpt_pkg::OFS_A_MATCH;
  wire logic wr_b_match = bus_req.wr && bus_req.addr == gpt_pkg::OFS_B_MATCH;
  wire logic wr_a_pre = bus_req.wr && bus_req.addr == gpt_pkg::OFS_A_PRESCALE;
  wire logic wr_b_pre = bus_req.wr && bus_req.addr == gpt_pkg::OFS_B_PRESCALE;

  // ****************************************
  // mode and stall qualifiers
  // ****************************************
  // config codes
  wire logic mode_os32 = cfg_q == gpt_pkg::CFG_OS32;
  wire logic mode_rtc = cfg_q == gpt_pkg::CFG_RTC32;
  // either 32-bit code makes one timer
  wire logic mode_w32 = mode_os32 || mode_rtc;
  wire logic [31:0] cnt32 = cnt_q;
  wire logic [31:0] load32 = load_q;
  wire logic [31:0] match32 = match_q;
  wire logic a_periodic = a_mode_q == gpt_pkg::MODE_PERIODIC;
  wire logic b_periodic = b_mode_q == gpt_pkg::MODE_PERIODIC;
  wire logic [1:0] half_periodic = {b_periodic, a_periodic};
  wire logic [1:0] half_run = {ctl_q[gpt_pkg::CTL_B_RUN], ctl_q[gpt_pkg::CTL_A_RUN]};
  wire logic [1:0] half_stall = {2{dbg_halt}} & {ctl_q[gpt_pkg::CTL_B_STALL], ctl_q[gpt_pkg::CTL_A_STALL]};
  wire logic rtc_stall = (|half_stall) && !ctl_q[gpt_pkg::CTL_RTC_OVR];
  wire logic rtc_first = wr_cfg && wdata[2:0] == gpt_pkg::CFG_RTC32 && !mode_rtc;

  // ****************************************
  // rtc input divider
  // ****************************************
  // the pin is only ever an input in the modes covered here
  assign capture_compare_pin_0_out = 1'b0;
  assign capture_compare_pin_0_oe = 1'b0;
  wire logic pin_rise = pin_q && !pin_prev_q;
  wire logic div_wrap = div_q == gpt_pkg::RTC_DIV_W'(RTC_DIV - 1);
  // one tick per RTC_DIV input edges
  wire logic rtc_tick = mode_rtc && half_run[0] && pin_rise && div_wrap;
  // divider restarts whenever the counter is not running, so a tick is a whole second
  assign div_d = !(mode_rtc && half_run[0]) ? '0 :
                 !pin_rise ? div_q :
                 div_wrap ? '0 : gpt_pkg::RTC_DIV_W'(div_q + 1'b1);

  // ****************************************
  // counter and control next state
  // ****************************************
  always_comb begin
    cnt_d = cnt_q;
    load_d = load_q;
    match_d = match_q;
    ctl_d = ctl_q;
    timeout_evt = 2'b00;
    rtc_evt = 1'b0;
    // 32-bit load write fills both halves
    if (wr_a_load && mode_w32) begin
      load_d = wdata;
    end else if (wr_a_load) begin
      load_d[0] = wdata[15:0];
    end
    if (wr_b_load && !mode_w32) begin
      load_d[1] = wdata[15:0];
    end
    if (wr_a_match && mode_w32) begin
      match_d = wdata;
    end else if (wr_a_match) begin
      match_d[0] = wdata[15:0];
    end
    if (wr_b_match && !mode_w32) begin
      match_d[1] = wdata[15:0];
    end
    if (mode_os32) begin
      // load write reaches the counter next cycle
      if (wr_a_load) begin
        cnt_d = wdata;
      end else if (half_run[0] && !half_stall[0]) begin
        if (cnt32 == 32'h0000_0000) begin
          cnt_d = load32;
          timeout_evt[0] = 1'b1;
          if (!a_periodic) begin
            ctl_d[gpt_pkg::CTL_A_RUN] = 1'b0;
          end
        end else begin
          cnt_d = cnt32 - 32'h0000_0001;
        end
      end
    end else if (mode_rtc) begin
      if (rtc_tick && !rtc_stall) begin
        if (cnt32 == match32) begin
          cnt_d = 32'h0000_0000;
          rtc_evt = 1'b1;
        end else begin
          cnt_d = cnt32 + 32'h0000_0001;
        end
      end
    end else begin
      for (int h = 0; h < 2; h++) begin
        if ((h == 0 && wr_a_load) || (h == 1 && wr_b_load)) begin
          cnt_d[h] = wdata[15:0];
        end else if (half_run[h] && !half_stall[h]) begin
          if (cnt_q[h] == 16'h0000) begin
            cnt_d[h] = load_q[h];
            timeout_evt[h] = 1'b1;
            if (!half_periodic[h]) begin
              ctl_d[h == 0 ? gpt_pkg::CTL_A_RUN : gpt_pkg::CTL_B_RUN] = 1'b0;
            end
          end else begin
            cnt_d[h] = cnt_q[h] - 16'h0001;
          end
        end
      end
    end
    if (rtc_first) begin
      cnt_d = gpt_pkg::RTC_FIRST_LOAD;
    end
    // a software write to control lands after any hardware clear
    if (wr_ctl) begin
      ctl_d = wdata[gpt_pkg::CTL_W-1:0];
    end
  end

  // ****************************************
  // simple registers and flags
  // ****************************************
  assign cfg_d = wr_cfg ? wdata[2:0] : cfg_q;
  assign a_mode_d = wr_a_mode ? wdata[gpt_pkg::MODE_W-1:0] : a_mode_q;
  assign b_mode_d = wr_b_mode ? wdata[gpt_pkg::MODE_W-1:0] : b_mode_q;
  assign mask_d = wr_mask ? wdata[gpt_pkg::IRQ_W-1:0] : mask_q;
  assign pre_d[0] = wr_a_pre ? wdata[7:0] : pre_q[0];
  assign pre_d[1] = wr_b_pre ? wdata[7:0] : pre_q[1];
  wire logic [gpt_pkg::IRQ_W-1:0] clr_bits = wr_clear ? wdata[gpt_pkg::IRQ_W-1:0] : '0;
  logic [gpt_pkg::IRQ_W-1:0] set_bits;
  always_comb begin
    set_bits = '0;
    set_bits[gpt_pkg::IRQ_A_TO] = timeout_evt[0];
    set_bits[gpt_pkg::IRQ_B_TO] = timeout_evt[1];
    set_bits[gpt_pkg::IRQ_RTC] = rtc_evt;
  end
  // sticky, a new event beats a clear
  // rtc flag cleared by its clear bit
  assign raw_d = (raw_q & ~clr_bits) | set_bits;
  wire logic [gpt_pkg::IRQ_W-1:0] masked = raw_q & mask_q;
  assign irq = |masked;
  assign adc_d = timeout_evt[0] && ctl_q[gpt_pkg::CTL_A_ADC];
  assign adc_trigger = adc_q;

  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        gpt_pkg::OFS_WIDTH_CFG: rdata_d = {29'h0, cfg_q};
        gpt_pkg::OFS_A_MODE: rdata_d = {30'h0, a_mode_q};
        gpt_pkg::OFS_B_MODE: rdata_d = {30'h0, b_mode_q};
        gpt_pkg::OFS_CTRL: rdata_d = {16'h0, ctl_q};
        gpt_pkg::OFS_IRQ_MASK: rdata_d = {16'h0, mask_q};
        gpt_pkg::OFS_RAW_IRQ: rdata_d = {16'h0, raw_q};
        gpt_pkg::OFS_MASKED_IRQ: rdata_d = {16'h0, masked};
        gpt_pkg::OFS_A_LOAD: rdata_d = mode_w32 ? load32 : {16'h0, load_q[0]};
        gpt_pkg::OFS_B_LOAD: rdata_d = {16'h0, load_q[1]};
        gpt_pkg::OFS_A_MATCH: rdata_d = mode_w32 ? match32 : {16'h0, match_q[0]};
        gpt_pkg::OFS_B_MATCH: rdata_d = {16'h0, match_q[1]};
        gpt_pkg::OFS_A_PRESCALE: rdata_d = {24'h0, pre_q[0]};
        gpt_pkg::OFS_B_PRESCALE: rdata_d = {24'h0, pre_q[1]};
        gpt_pkg::OFS_A_COUNT: rdata_d = mode_w32 ? cnt32 : {16'h0, cnt_q[0]};
        gpt_pkg::OFS_B_COUNT: rdata_d = {16'h0, cnt_q[1]};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end
  assign rdata = rdata_q;

  // ****************************************
  // flip-flops
  // ****************************************
  // inactive reset state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= gpt_pkg::CFG_OS32;
      a_mode_q <= '0;
      b_mode_q <= '0;
      ctl_q <= '0;
      mask_q <= '0;
      raw_q <= '0;
      cnt_q <= {gpt_pkg::RST_COUNT, gpt_pkg::RST_COUNT};
      load_q <= {gpt_pkg::RST_LOAD, gpt_pkg::RST_LOAD};
      match_q <= '0;
      pre_q <= {gpt_pkg::RST_PRESCALE, gpt_pkg::RST_PRESCALE};
      rdata_q <= '0;
      adc_q <= 1'b0;
      pin_q <= 1'b0;
      pin_prev_q <= 1'b0;
      div_q <= '0;
    end else begin
      cfg_q <= cfg_d;
      a_mode_q <= a_mode_d;
      b_mode_q <= b_mode_d;
      ctl_q <= ctl_d;
      mask_q <= mask_d;
      raw_q <= raw_d;
      cnt_q <= cnt_d;
      load_q <= load_d;
      match_q <= match_d;
      pre_q <= pre_d;
      rdata_q <= rdata_d;
      adc_q <= adc_d;
      pin_q <= capture_compare_pin_0_in;
      pin_prev_q <= pin_q;
      div_q <= div_d;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  wire logic os32_live = mode_os32 && half_run[0] && !half_stall[0] && !wr_a_load && !rtc_first;

  property p_reset_state;
    @(posedge clk_sys) $rose(rst_n) |-> cnt32 == 32'hffff_ffff && load32 == 32'hffff_ffff
      && ctl_q == '0 && pre_q == '0 && irq == 1'b0;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad state after reset");

  property p_split_load;
    @(posedge clk_sys) disable iff (!rst_n) wr_a_load && mode_w32 |=> load32 == $past(wdata);
  endproperty
  a_split_load: assert property (p_split_load) else $error("32-bit load not split");

  property p_joined_read;
    @(posedge clk_sys) disable iff (!rst_n)
      bus_req.rd && bus_req.addr == gpt_pkg::OFS_A_COUNT && mode_w32 |=> rdata == $past(cnt32);
  endproperty
  a_joined_read: assert property (p_joined_read) else $error("joined count read wrong");

  property p_count_down;
    @(posedge clk_sys) disable iff (!rst_n) os32_live && cnt32 != 0 |=> cnt32 == $past(cnt32) - 32'h1;
  endproperty
  a_count_down: assert property (p_count_down) else $error("no decrement");

  property p_zero_reload;
    @(posedge clk_sys) disable iff (!rst_n) os32_live && cnt32 == 0 |=> cnt32 == $past(load32)
      && raw_q[gpt_pkg::IRQ_A_TO];
  endproperty
  a_zero_reload: assert property (p_zero_reload) else $error("no reload or flag at zero");

  property p_one_shot_stop;
    @(posedge clk_sys) disable iff (!rst_n) os32_live && cnt32 == 0 && !a_periodic && !wr_ctl
      |=> !ctl_q[gpt_pkg::CTL_A_RUN] ##1 $stable(cnt32);
  endproperty
  a_one_shot_stop: assert property (p_one_shot_stop) else $error("one-shot kept running");

  property p_flag_sticky;
    @(posedge clk_sys) disable iff (!rst_n) raw_q[gpt_pkg::IRQ_A_TO] && !wr_clear |=> raw_q[gpt_pkg::IRQ_A_TO];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("time-out flag lost");

  property p_masked_irq;
    @(posedge clk_sys) disable iff (!rst_n) raw_q[gpt_pkg::IRQ_RTC] && mask_q[gpt_pkg::IRQ_RTC] |-> irq;
  endproperty
  a_masked_irq: assert property (p_masked_irq) else $error("unmasked flag without irq");

  property p_adc_gate;
    @(posedge clk_sys) disable iff (!rst_n) adc_trigger |-> $past(ctl_q[gpt_pkg::CTL_A_ADC]) && $past(timeout_evt[0]);
  endproperty
  a_adc_gate: assert property (p_adc_gate) else $error("trigger without enable");

  property p_live_load;
    @(posedge clk_sys) disable iff (!rst_n) wr_a_load && mode_os32 |=> cnt32 == $past(wdata);
  endproperty
  a_live_load: assert property (p_live_load) else $error("load write not taken");

  property p_debug_freeze;
    @(posedge clk_sys) disable iff (!rst_n) mode_os32 && half_stall[0] && !wr_a_load && !rtc_first
      |=> $stable(cnt32);
  endproperty
  a_debug_freeze: assert property (p_debug_freeze) else $error("count moved in halt");

  property p_rtc_first;
    @(posedge clk_sys) disable iff (!rst_n) rtc_first |=> cnt32 == gpt_pkg::RTC_FIRST_LOAD;
  endproperty
  a_rtc_first: assert property (p_rtc_first) else $error("rtc first load not one");

  property p_rtc_roll;
    @(posedge clk_sys) disable iff (!rst_n) rtc_tick && !rtc_stall && cnt32 == match32 && !rtc_first
      |=> cnt32 == 32'h0 && raw_q[gpt_pkg::IRQ_RTC];
  endproperty
  a_rtc_roll: assert property (p_rtc_roll) else $error("rtc no roll on match");

  c_one_shot: cover property (@(posedge clk_sys) disable iff (!rst_n) os32_live && cnt32 == 0 && !a_periodic);
  c_periodic: cover property (@(posedge clk_sys) disable iff (!rst_n) os32_live && cnt32 == 0 && a_periodic);
  c_rtc_match: cover property (@(posedge clk_sys) disable iff (!rst_n) rtc_evt);
  c_half_b: cover property (@(posedge clk_sys) disable iff (!rst_n) timeout_evt[1]);

endmodule : gpt_general_timer_unit
`default_nettype wire

// ### sim/gpt_general_timer_unit_tb.sv
// self-checking testbench for the general timer unit
`timescale 1ns/1ps
`default_nettype none

module gpt_general_timer_unit_tb;
  // short rtc divider keeps the run brief
  localparam int DIV = 4;
  logic clk_sys;
  logic rst_n;
  gpt_pkg::gpt_bus_req_t bus_req;
  logic [31:0] rdata;
  logic dbg_halt;
  logic pin_in;
  logic pin_out;
  logic pin_oe;
  logic irq;
  logic adc_trigger;
  int fail_count = 0;
  int checks_done = 0;
  int adc_seen = 0;

  gpt_general_timer_unit #(.RTC_DIV(DIV)) dut (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .bus_req(bus_req),
    .rdata(rdata),
    .dbg_halt(dbg_halt),
    .capture_compare_pin_0_in(pin_in),
    .capture_compare_pin_0_out(pin_out),
    .capture_compare_pin_0_oe(pin_oe),
    .irq(irq),
    .adc_trigger(adc_trigger)
  );

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // pulses are one cycle long, so count them where they stand
  always @(posedge clk_sys) begin
    if (adc_trigger === 1'b1) begin
      adc_seen <= adc_seen + 1;
    end
  end

  // ****************************************
  // compare, bus and pin helpers
  // ****************************************
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : cmp32

  task automatic cmp1(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %0t %s: got %b expected %b", $time, what, got, exp);
    end
  endtask : cmp1

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge clk_sys);
    bus_req.wr <= 1'b0;
  endtask : bus_wr

  // read data stand only in the cycle after the strobe edge
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk_sys);
    bus_req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : bus_rd

  task automatic rd_cmp(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    bus_rd(a, d);
    cmp32(d, exp, what);
  endtask : rd_cmp

  // bench drives the rtc clock pin
  // edges held several cycles so the two-flop sampler never misses one
  task automatic pin_edges(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      pin_in <= 1'b1;
      repeat (3) @(posedge clk_sys);
      pin_in <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
  endtask : pin_edges

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    cmp1(irq, 1'b0, "irq idle");
    cmp1(pin_oe, 1'b0, "pin not driven");
    cmp1(pin_out, 1'b0, "pin out low");
    rd_cmp(gpt_pkg::OFS_WIDTH_CFG, 32'h0, "cfg");
    rd_cmp(gpt_pkg::OFS_A_MODE, 32'h0, "mode a");
    rd_cmp(gpt_pkg::OFS_CTRL, 32'h0, "ctrl");
    rd_cmp(gpt_pkg::OFS_IRQ_MASK, 32'h0, "mask");
    rd_cmp(gpt_pkg::OFS_RAW_IRQ, 32'h0, "raw");
    rd_cmp(gpt_pkg::OFS_A_LOAD, 32'hffff_ffff, "joined load");
    rd_cmp(gpt_pkg::OFS_A_COUNT, 32'hffff_ffff, "joined count");
    rd_cmp(gpt_pkg::OFS_B_COUNT, 32'h0000_ffff, "upper count");
    rd_cmp(gpt_pkg::OFS_A_PRESCALE, 32'h0, "prescale a");
    rd_cmp(gpt_pkg::OFS_B_PRESCALE, 32'h0, "prescale b");
    rd_cmp(8'h40, 32'h0, "unmapped");
    $display("test reset done");
  endtask : t_reset

  task automatic t_oneshot;
    int a0;
    int i;
    bus_wr(gpt_pkg::OFS_B_MODE, {30'h0, gpt_pkg::MODE_PERIODIC});
    bus_wr(gpt_pkg::OFS_A_MODE, {30'h0, gpt_pkg::MODE_ONE_SHOT});
    bus_wr(gpt_pkg::OFS_IRQ_MASK, 32'h1);
    bus_wr(gpt_pkg::OFS_A_LOAD, 32'h0000_0002);
    rd_cmp(gpt_pkg::OFS_B_LOAD, 32'h0, "upper load half");
    a0 = adc_seen;
    bus_wr(gpt_pkg::OFS_CTRL, 32'h21);
    for (i = 0; i < 20 && adc_seen == a0; i++) @(posedge clk_sys);
    repeat (8) @(posedge clk_sys);
    cmp1(adc_seen == a0 + 1, 1'b1, "single trigger");
    rd_cmp(gpt_pkg::OFS_CTRL, 32'h20, "run cleared");
    rd_cmp(gpt_pkg::OFS_A_COUNT, 32'h0000_0002, "reloaded");
    rd_cmp(gpt_pkg::OFS_RAW_IRQ, 32'h1, "raw timeout");
    rd_cmp(gpt_pkg::OFS_MASKED_IRQ, 32'h1, "masked timeout");
    cmp1(irq, 1'b1, "irq raised");
    rd_cmp(gpt_pkg::OFS_RAW_IRQ, 32'h1, "raw sticky");
    bus_wr(gpt_pkg::OFS_IRQ_CLEAR, 32'h1);
    rd_cmp(gpt_pkg::OFS_RAW_IRQ, 32'h0, "raw cleared");
    cmp1(irq, 1'b0, "irq cleared");
    $display("test oneshot done");
  endtask : t_oneshot

  task automatic t_periodic;
    int a0;
    logic [31:0] v;
    logic [31:0] w;
    a0 = adc_seen;
    bus_wr(gpt_pkg::OFS_A_MODE, {30'h0, gpt_pkg::MODE_PERIODIC});
    bus_wr(gpt_pkg::OFS_A_LOAD, 32'h0000_0003);
    bus_wr(gpt_pkg::OFS_CTRL, 32'h1);
    repeat (12) @(posedge clk_sys);
    rd_cmp(gpt_pkg::OFS_CTRL, 32'h1, "periodic keeps run");
    rd_cmp(gpt_pkg::OFS_RAW_IRQ, 32'h1, "periodic timeout");
    cmp1(adc_seen == a0, 1'b1, "no trigger when disabled");
    bus_wr(gpt_pkg::OFS_A_LOAD, 32'h0000_0100);
    bus_rd(gpt_pkg::OFS_A_COUNT, v);
    cmp1(v <= 32'h100 && v >= 32'hf8, 1'b1, "count from new load");
    bus_wr(gpt_pkg::OFS_CTRL, 32'h3);
    dbg_halt <= 1'b1;
    bus_rd(gpt_pkg::OFS_A_COUNT, v);
    repeat (5) @(posedge clk_sys);
    bus_rd(gpt_pkg::OFS_A_COUNT, w);
    cmp32(w, v, "stall holds count");
    @(posedge clk_sys);
    dbg_halt <= 1'b0;
    repeat (5) @(posedge clk_sys);
    bus_rd(gpt_pkg::OFS_A_COUNT, w);
    cmp1(w < v, 1'b1, "count resumes");
    bus_wr(gpt_pkg::OFS_CTRL, 32'h0);
    bus_wr(gpt_pkg::OFS_IRQ_CLEAR, 32'h1);
    $display("test periodic done");
  endtask : t_periodic

  task automatic t_rtc;
    bus_wr(gpt_pkg::OFS_WIDTH_CFG, {29'h0, gpt_pkg::CFG_RTC32});
    rd_cmp(gpt_pkg::OFS_A_COUNT, gpt_pkg::RTC_FIRST_LOAD, "first load");
    bus_wr(gpt_pkg::OFS_A_MATCH, 32'h0000_0002);
    bus_wr(gpt_pkg::OFS_IRQ_MASK, 32'h8);
    bus_wr(gpt_pkg::OFS_CTRL, 32'h1);
    pin_edges(DIV - 1);
    rd_cmp(gpt_pkg::OFS_A_COUNT, 32'h1, "no tick yet");
    pin_edges(1);
    rd_cmp(gpt_pkg::OFS_A_COUNT, 32'h2, "one tick up");
    pin_edges(DIV);
    rd_cmp(gpt_pkg::OFS_A_COUNT, 32'h0, "match rolls over");
    rd_cmp(gpt_pkg::OFS_RAW_IRQ, 32'h8, "rtc raw");
    rd_cmp(gpt_pkg::OFS_MASKED_IRQ, 32'h8, "rtc masked");
    cmp1(irq, 1'b1, "rtc irq");
    bus_wr(gpt_pkg::OFS_IRQ_CLEAR, 32'h8);
    rd_cmp(gpt_pkg::OFS_MASKED_IRQ, 32'h0, "rtc cleared");
    cmp1(irq, 1'b0, "rtc irq cleared");
    bus_wr(gpt_pkg::OFS_CTRL, 32'h13);
    dbg_halt <= 1'b1;
    pin_edges(DIV);
    rd_cmp(gpt_pkg::OFS_A_COUNT, 32'h1, "override keeps running");
    bus_wr(gpt_pkg::OFS_CTRL, 32'h3);
    pin_edges(DIV);
    rd_cmp(gpt_pkg::OFS_A_COUNT, 32'h1, "stall freezes rtc");
    @(posedge clk_sys);
    dbg_halt <= 1'b0;
    bus_wr(gpt_pkg::OFS_CTRL, 32'h0);
    $display("test rtc done");
  endtask : t_rtc

  task automatic t_half16;
    bus_wr(gpt_pkg::OFS_WIDTH_CFG, {29'h0, gpt_pkg::CFG_HALF16});
    bus_wr(gpt_pkg::OFS_A_LOAD, 32'habcd_5678);
    bus_wr(gpt_pkg::OFS_B_LOAD, 32'h0000_1234);
    rd_cmp(gpt_pkg::OFS_A_LOAD, 32'h0000_5678, "half a load alone");
    rd_cmp(gpt_pkg::OFS_B_LOAD, 32'h0000_1234, "half b load alone");
    rd_cmp(gpt_pkg::OFS_A_COUNT, 32'h0000_5678, "half a count alone");
    bus_wr(gpt_pkg::OFS_B_MODE, {30'h0, gpt_pkg::MODE_ONE_SHOT});
    bus_wr(gpt_pkg::OFS_B_LOAD, 32'h0000_0002);
    bus_wr(gpt_pkg::OFS_CTRL, 32'h100);
    repeat (8) @(posedge clk_sys);
    rd_cmp(gpt_pkg::OFS_RAW_IRQ, 32'h100, "half b timeout alone");
    rd_cmp(gpt_pkg::OFS_CTRL, 32'h0, "half b one-shot stops");
    rd_cmp(gpt_pkg::OFS_B_COUNT, 32'h0000_0002, "half b reloaded");
    rd_cmp(gpt_pkg::OFS_A_COUNT, 32'h0000_5678, "half a untouched");
    $display("test half16 done");
  endtask : t_half16

  // ****************************************
  // run control
  // ****************************************
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  initial begin
    rst_n = 1'b0;
    bus_req = '0;
    dbg_halt = 1'b0;
    pin_in = 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset();
    t_oneshot();
    t_periodic();
    t_rtc();
    t_half16();
    print_verdict();
  end

  // all scenarios need well under a thousand cycles
  initial begin
    #(100 * 5000);
    fail_count++;
    $display("FAIL %0t watchdog expired", $time);
    print_verdict();
  end
endmodule : gpt_general_timer_unit_tb

`default_nettype wire
